// ==== core/cbs_bus_set.sv ====
// internal bus set: read, write and program buses between the functional units and memory interface
//
// Summary of operation
// - coefficient read data is 32 bits; second and primary read data are 16 bits
// - coefficient data comes from on-chip memory only and goes only to compute unit
// - coefficient access to an off-chip address raises bus error and is not performed
// - quad read uses coefficient, second and primary read buses in one cycle
// - second and primary read data reach program flow, address and compute units
// - dual read uses second and primary buses; single read uses primary only
// - read address buses carry 23-bit word addresses; data returns on matching bus
// - fixed pairing: coefficient, second, and primary address buses serve their data buses
// - every data-space address comes from the address unit
// - program data bus moves 32-bit code units to the decode unit
// - program address bus carries a 24-bit byte address for the fetched code
// - two 16-bit write data buses sourced from program flow, address or compute
// - dual write uses both write data buses; single write uses primary only
// - write address buses carry 23-bit addresses; memory takes the matching data
// - primary write address serves single and dual writes; second addresses second data
// - every transfer to program, data or I/O space passes through memory interface
`timescale 1ns/1ps
module cbs_bus_set
  import cbs_pkg::*;
#(
  parameter logic [DATA_AW-1:0] INT_WORDS = INT_WORDS_DEF
) (
  input  wire logic               sys_clk,
  input  wire logic               reset,
  // read request from the address unit
  input  wire logic [2:0]         au_rd_kind,
  input  wire logic [1:0]         au_rd_dest,
  input  wire logic [DATA_AW-1:0] au_coeff_addr,
  input  wire logic [DATA_AW-1:0] au_second_addr,
  input  wire logic [DATA_AW-1:0] au_primary_addr,
  // write request from the address unit, data from a chosen unit
  input  wire logic [1:0]         au_wr_kind,
  input  wire logic [1:0]         au_wr_src,
  input  wire logic [DATA_AW-1:0] au_wr_primary_addr,
  input  wire logic [DATA_AW-1:0] au_wr_second_addr,
  input  wire logic [WORD_W-1:0]  pf_wr_primary_data,
  input  wire logic [WORD_W-1:0]  pf_wr_second_data,
  input  wire logic [WORD_W-1:0]  au_wr_primary_data,
  input  wire logic [WORD_W-1:0]  au_wr_second_data,
  input  wire logic [WORD_W-1:0]  cu_wr_primary_data,
  input  wire logic [WORD_W-1:0]  cu_wr_second_data,
  // program fetch from the program flow unit
  input  wire logic               pf_fetch_req,
  input  wire logic [PROG_AW-1:0] pf_fetch_addr,
  // memory interface unit side
  output logic                    coeff_read_address_valid,
  output logic [DATA_AW-1:0]      coeff_read_address_bus,
  output logic                    second_read_address_valid,
  output logic [DATA_AW-1:0]      second_read_address_bus,
  output logic                    primary_read_address_valid,
  output logic [DATA_AW-1:0]      primary_read_address_bus,
  input  wire logic               mem_coeff_valid,
  input  wire logic [COEFF_W-1:0] mem_coeff_data,
  input  wire logic               mem_second_valid,
  input  wire logic [WORD_W-1:0]  mem_second_data,
  input  wire logic               mem_primary_valid,
  input  wire logic [WORD_W-1:0]  mem_primary_data,
  output logic                    primary_write_valid,
  output logic [DATA_AW-1:0]      primary_write_address_bus,
  output logic [WORD_W-1:0]       primary_write_data_bus,
  output logic                    second_write_valid,
  output logic [DATA_AW-1:0]      second_write_address_bus,
  output logic [WORD_W-1:0]       second_write_data_bus,
  output logic                    program_read_address_valid,
  output logic [PROG_AW-1:0]      program_read_address_bus,
  input  wire logic               mem_code_valid,
  input  wire logic [CODE_W-1:0]  mem_code_data,
  // core side returns
  output logic                    cu_coeff_valid,
  output logic [COEFF_W-1:0]      coeff_read_data_bus,
  output logic [WORD_W-1:0]       second_read_data_bus,
  output logic [WORD_W-1:0]       primary_read_data_bus,
  output logic                    pf_second_valid,
  output logic                    pf_primary_valid,
  output logic                    au_second_valid,
  output logic                    au_primary_valid,
  output logic                    cu_second_valid,
  output logic                    cu_primary_valid,
  output logic                    decode_code_valid,
  output logic [CODE_W-1:0]       program_read_data_bus,
  output logic                    bus_error
);

  // read decode
  wire logic use_coeff   = (au_rd_kind == CBS_RD_COEFF) || (au_rd_kind == CBS_RD_QUAD);
  wire logic use_second  = (au_rd_kind == CBS_RD_DUAL) || (au_rd_kind == CBS_RD_QUAD);
  wire logic use_primary = (au_rd_kind == CBS_RD_SINGLE) || use_second;

  // off-chip coefficient fetch kills the whole access, not just the coefficient lane
  wire logic coeff_offchip = use_coeff && (au_coeff_addr >= INT_WORDS);
  wire logic rd_allow      = !coeff_offchip;
  wire logic rd_coeff_go   = use_coeff && rd_allow;
  wire logic rd_second_go  = use_second && rd_allow;
  wire logic rd_primary_go = use_primary && rd_allow;

  // write decode and data source selection
  wire logic wr_primary_go = (au_wr_kind == CBS_WR_SINGLE) || (au_wr_kind == CBS_WR_DUAL);
  wire logic wr_second_go  = (au_wr_kind == CBS_WR_DUAL);
  wire logic [WORD_W-1:0] wr_primary_sel =
    (au_wr_src == CBS_UNIT_PFLOW) ? pf_wr_primary_data :
    (au_wr_src == CBS_UNIT_ADDR)  ? au_wr_primary_data :
                                    cu_wr_primary_data;
  wire logic [WORD_W-1:0] wr_second_sel =
    (au_wr_src == CBS_UNIT_PFLOW) ? pf_wr_second_data :
    (au_wr_src == CBS_UNIT_ADDR)  ? au_wr_second_data :
                                    cu_wr_second_data;

  // code arrives in four-byte units, so the two low byte-address bits are dropped
  wire logic [PROG_AW-1:0] fetch_aligned =
    {pf_fetch_addr[PROG_AW-1:CODE_ALIGN_W], {CODE_ALIGN_W{1'b0}}};

  // destination of the outstanding second/primary read; one read in flight at a time
  cbs_unit_t dest_q;
  cbs_unit_t dest_d;
  assign dest_d = rd_second_go || rd_primary_go ? cbs_unit_t'(au_rd_dest) : dest_q;

  wire logic to_pf = (dest_q == CBS_UNIT_PFLOW);
  wire logic to_au = (dest_q == CBS_UNIT_ADDR);
  wire logic to_cu = (dest_q == CBS_UNIT_COMPUTE);

  logic bus_error_q;
  logic pf_second_q;
  logic pf_primary_q;
  logic au_second_q;
  logic au_primary_q;
  logic cu_second_q;
  logic cu_primary_q;

  // destination code 11 matches no unit, so its second and primary returns raise no strobe
  wire logic bus_error_d  = coeff_offchip;
  wire logic pf_second_d  = mem_second_valid && to_pf;
  wire logic pf_primary_d = mem_primary_valid && to_pf;
  wire logic au_second_d  = mem_second_valid && to_au;
  wire logic au_primary_d = mem_primary_valid && to_au;
  wire logic cu_second_d  = mem_second_valid && to_cu;
  wire logic cu_primary_d = mem_primary_valid && to_cu;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dest_q <= CBS_UNIT_PFLOW;
    end else begin
      dest_q <= dest_d;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bus_error_q <= RST_VALID;
    end else begin
      bus_error_q <= bus_error_d;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pf_second_q <= RST_VALID;
    end else begin
      pf_second_q <= pf_second_d;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pf_primary_q <= RST_VALID;
    end else begin
      pf_primary_q <= pf_primary_d;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      au_second_q <= RST_VALID;
    end else begin
      au_second_q <= au_second_d;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      au_primary_q <= RST_VALID;
    end else begin
      au_primary_q <= au_primary_d;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cu_second_q <= RST_VALID;
    end else begin
      cu_second_q <= cu_second_d;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cu_primary_q <= RST_VALID;
    end else begin
      cu_primary_q <= cu_primary_d;
    end
  end

  assign bus_error        = bus_error_q;
  assign pf_second_valid  = pf_second_q;
  assign pf_primary_valid = pf_primary_q;
  assign au_second_valid  = au_second_q;
  assign au_primary_valid = au_primary_q;
  assign cu_second_valid  = cu_second_q;
  assign cu_primary_valid = cu_primary_q;

  // coefficient lane: return goes to the compute unit alone
  cbs_lane #(.AW(DATA_AW), .DW(COEFF_W)) u_coeff (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .req_valid    (rd_coeff_go),
    .req_addr     (au_coeff_addr),
    .req_data     ('0),
    .out_valid    (coeff_read_address_valid),
    .out_addr     (coeff_read_address_bus),
    .out_data     (),
    .ret_valid_in (mem_coeff_valid),
    .ret_data_in  (mem_coeff_data),
    .ret_valid    (cu_coeff_valid),
    .ret_data     (coeff_read_data_bus)
  );

  cbs_lane #(.AW(DATA_AW), .DW(WORD_W)) u_second_rd (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .req_valid    (rd_second_go),
    .req_addr     (au_second_addr),
    .req_data     ('0),
    .out_valid    (second_read_address_valid),
    .out_addr     (second_read_address_bus),
    .out_data     (),
    .ret_valid_in (mem_second_valid),
    .ret_data_in  (mem_second_data),
    .ret_valid    (),
    .ret_data     (second_read_data_bus)
  );

  cbs_lane #(.AW(DATA_AW), .DW(WORD_W)) u_primary_rd (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .req_valid    (rd_primary_go),
    .req_addr     (au_primary_addr),
    .req_data     ('0),
    .out_valid    (primary_read_address_valid),
    .out_addr     (primary_read_address_bus),
    .out_data     (),
    .ret_valid_in (mem_primary_valid),
    .ret_data_in  (mem_primary_data),
    .ret_valid    (),
    .ret_data     (primary_read_data_bus)
  );

  cbs_lane #(.AW(DATA_AW), .DW(WORD_W)) u_primary_wr (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .req_valid    (wr_primary_go),
    .req_addr     (au_wr_primary_addr),
    .req_data     (wr_primary_sel),
    .out_valid    (primary_write_valid),
    .out_addr     (primary_write_address_bus),
    .out_data     (primary_write_data_bus),
    .ret_valid_in (1'b0),
    .ret_data_in  ('0),
    .ret_valid    (),
    .ret_data     ()
  );

  cbs_lane #(.AW(DATA_AW), .DW(WORD_W)) u_second_wr (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .req_valid    (wr_second_go),
    .req_addr     (au_wr_second_addr),
    .req_data     (wr_second_sel),
    .out_valid    (second_write_valid),
    .out_addr     (second_write_address_bus),
    .out_data     (second_write_data_bus),
    .ret_valid_in (1'b0),
    .ret_data_in  ('0),
    .ret_valid    (),
    .ret_data     ()
  );

  // program path; no unit reaches memory except through these lanes
  cbs_lane #(.AW(PROG_AW), .DW(CODE_W)) u_program (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .req_valid    (pf_fetch_req),
    .req_addr     (fetch_aligned),
    .req_data     ('0),
    .out_valid    (program_read_address_valid),
    .out_addr     (program_read_address_bus),
    .out_data     (),
    .ret_valid_in (mem_code_valid),
    .ret_data_in  (mem_code_data),
    .ret_valid    (decode_code_valid),
    .ret_data     (program_read_data_bus)
  );

endmodule : cbs_bus_set

// ==== core/cbs_pkg.sv ====
// shared widths, encodings and reset values for the internal bus set
package cbs_pkg;
  localparam int unsigned DATA_AW       = 23;
  localparam int unsigned PROG_AW       = 24;
  localparam int unsigned WORD_W        = 16;
  localparam int unsigned COEFF_W       = 32;
  localparam int unsigned CODE_W        = 32;
  localparam int unsigned CODE_BYTES    = 4;
  localparam int unsigned CODE_ALIGN_W  = 2;
  localparam int unsigned DATA_WORD_BYTES = 2;
  localparam logic        RST_VALID     = 1'b0;
  localparam logic [22:0] INT_WORDS_DEF = 23'h010000;

  typedef enum logic [2:0] {
    CBS_RD_IDLE   = 3'b000,
    CBS_RD_SINGLE = 3'b001,
    CBS_RD_DUAL   = 3'b010,
    CBS_RD_COEFF  = 3'b011,
    CBS_RD_QUAD   = 3'b100
  } cbs_rd_kind_t;

  typedef enum logic [1:0] {
    CBS_WR_IDLE   = 2'b00,
    CBS_WR_SINGLE = 2'b01,
    CBS_WR_DUAL   = 2'b10
  } cbs_wr_kind_t;

  typedef enum logic [1:0] {
    CBS_UNIT_PFLOW   = 2'b00,
    CBS_UNIT_ADDR    = 2'b01,
    CBS_UNIT_COMPUTE = 2'b10
  } cbs_unit_t;
endpackage : cbs_pkg

// ==== core/cbs_lane.sv ====
// one bus lane: registered request toward memory, registered return toward the core
`timescale 1ns/1ps
module cbs_lane
  import cbs_pkg::*;
#(
  parameter int unsigned AW = 23,
  parameter int unsigned DW = 16
) (
  input  wire logic          sys_clk,
  input  wire logic          reset,
  input  wire logic          req_valid,
  input  wire logic [AW-1:0] req_addr,
  input  wire logic [DW-1:0] req_data,
  output logic               out_valid,
  output logic [AW-1:0]      out_addr,
  output logic [DW-1:0]      out_data,
  input  wire logic          ret_valid_in,
  input  wire logic [DW-1:0] ret_data_in,
  output logic               ret_valid,
  output logic [DW-1:0]      ret_data
);
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      out_valid <= RST_VALID;
      out_addr  <= '0;
      out_data  <= '0;
      ret_valid <= RST_VALID;
      ret_data  <= '0;
    end else begin
      out_valid <= req_valid;
      ret_valid <= ret_valid_in;
      if (req_valid) begin
        out_addr <= req_addr;
        out_data <= req_data;
      end
      if (ret_valid_in) begin
        ret_data <= ret_data_in;
      end
    end
  end
endmodule : cbs_lane

// ==== dv/cbs_bus_set_assertions.sv ====
// checker for lane pairing, bus error, write pairing and program fetch of the bus set
`timescale 1ns/1ps
module cbs_bus_set_assertions
  import cbs_pkg::*;
#(
  parameter logic [22:0] INT_WORDS = INT_WORDS_DEF
) (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic [2:0]  au_rd_kind,
  input wire logic [22:0] au_coeff_addr,
  input wire logic [22:0] au_second_addr,
  input wire logic [22:0] au_primary_addr,
  input wire logic [1:0]  au_wr_kind,
  input wire logic [22:0] au_wr_primary_addr,
  input wire logic [22:0] au_wr_second_addr,
  input wire logic        pf_fetch_req,
  input wire logic [23:0] pf_fetch_addr,
  input wire logic        coeff_read_address_valid,
  input wire logic        second_read_address_valid,
  input wire logic        primary_read_address_valid,
  input wire logic [22:0] second_read_address_bus,
  input wire logic [22:0] primary_read_address_bus,
  input wire logic        bus_error,
  input wire logic        primary_write_valid,
  input wire logic        second_write_valid,
  input wire logic [22:0] primary_write_address_bus,
  input wire logic [22:0] second_write_address_bus,
  input wire logic        program_read_address_valid,
  input wire logic [23:0] program_read_address_bus,
  input wire logic        mem_code_valid,
  input wire logic [31:0] mem_code_data,
  input wire logic        decode_code_valid,
  input wire logic [31:0] program_read_data_bus
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  sequence s_offchip;
    (au_rd_kind == CBS_RD_COEFF || au_rd_kind == CBS_RD_QUAD) && au_coeff_addr >= INT_WORDS;
  endsequence
  sequence s_no_lane;
    !coeff_read_address_valid && !second_read_address_valid && !primary_read_address_valid;
  endsequence
  a_single_pairing: assert property (au_rd_kind == CBS_RD_SINGLE |=>
    primary_read_address_valid && !second_read_address_valid && !coeff_read_address_valid
    && primary_read_address_bus == $past(au_primary_addr)) else $error("single read pairing wrong");
  a_dual_pairing: assert property (au_rd_kind == CBS_RD_DUAL |=>
    primary_read_address_valid && second_read_address_valid && !coeff_read_address_valid
    && second_read_address_bus == $past(au_second_addr)) else $error("dual read pairing wrong");
  a_quad_lanes: assert property (au_rd_kind == CBS_RD_QUAD && au_coeff_addr < INT_WORDS |=>
    coeff_read_address_valid && second_read_address_valid && primary_read_address_valid && !bus_error)
    else $error("quad read lanes wrong");
  a_offchip_error: assert property (s_offchip |=> s_no_lane ##0 bus_error)
    else $error("off-chip coefficient access not refused");
  a_write_single: assert property (au_wr_kind == CBS_WR_SINGLE |=>
    primary_write_valid && !second_write_valid && primary_write_address_bus == $past(au_wr_primary_addr))
    else $error("single write pairing wrong");
  a_write_dual: assert property (au_wr_kind == CBS_WR_DUAL |=>
    primary_write_valid && second_write_valid && second_write_address_bus == $past(au_wr_second_addr))
    else $error("dual write pairing wrong");
  a_fetch_align: assert property (pf_fetch_req |=> program_read_address_valid
    && program_read_address_bus == ($past(pf_fetch_addr) & 24'hfffffc)) else $error("fetch address wrong");
  a_code_return: assert property (mem_code_valid |=> decode_code_valid
    && program_read_data_bus == $past(mem_code_data)) else $error("code return wrong");
endmodule : cbs_bus_set_assertions

// ==== dv/cbs_mem_model.sv ====
// memory interface model: answers program, coefficient, second and primary reads
`timescale 1ns/1ps
module cbs_mem_model (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             slow,
  input  wire logic [3:0]       req_v,
  input  wire logic [3:0][23:0] req_a,
  output logic      [3:0]       ret_v,
  output logic      [3:0][31:0] ret_d
);
  logic [2:0][3:0]       v_q;
  logic [2:0][3:0][23:0] a_q;
  logic [3:0][23:0]      a_sel;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      v_q <= '0;
      a_q <= '0;
    end else begin
      v_q <= {v_q[1:0], req_v};
      a_q <= {a_q[1:0], req_a};
    end
  end
  // slow mode returns two cycles later than prompt mode
  assign ret_v = slow ? v_q[2] : v_q[0];
  assign a_sel = slow ? a_q[2] : a_q[0];
  // outside a return the lines show a swapped pattern so stale data never matches
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ret_d[i] = ret_v[i] ? {a_sel[i][15:0], ~a_sel[i][15:0]} : {~a_sel[i][15:0], a_sel[i][15:0]};
    end
  end
endmodule : cbs_mem_model

// ==== dv/cbs_bus_set_tb.sv ====
// self-checking testbench for the internal bus set
`timescale 1ns/1ps
module cbs_bus_set_tb;
  import cbs_pkg::*;
  logic              sys_clk = 1'b0, reset = 1'b1, pf_fetch_req = 1'b0, slow = 1'b0;
  logic [2:0]        au_rd_kind = 3'h0;
  logic [1:0]        au_rd_dest = 2'h0, au_wr_kind = 2'h0, au_wr_src = 2'h0;
  logic [22:0]       au_coeff_addr = '0, au_second_addr = '0, au_primary_addr = '0;
  logic [22:0]       au_wr_primary_addr = '0, au_wr_second_addr = '0;
  logic [15:0]       pf_wr_primary_data = 16'h1111, au_wr_primary_data = 16'h3333, cu_wr_primary_data = 16'h5555;
  logic [15:0]       pf_wr_second_data = 16'h2222, au_wr_second_data = 16'h4444, cu_wr_second_data = 16'h6666;
  logic [23:0]       pf_fetch_addr = '0, program_read_address_bus;
  logic              coeff_read_address_valid, second_read_address_valid, primary_read_address_valid;
  logic              mem_coeff_valid, mem_second_valid, mem_primary_valid, mem_code_valid;
  logic              primary_write_valid, second_write_valid, program_read_address_valid, bus_error;
  logic              cu_coeff_valid, pf_second_valid, pf_primary_valid, au_second_valid, au_primary_valid;
  logic              cu_second_valid, cu_primary_valid, decode_code_valid;
  logic [22:0]       coeff_read_address_bus, second_read_address_bus, primary_read_address_bus;
  logic [22:0]       primary_write_address_bus, second_write_address_bus;
  logic [15:0]       mem_second_data, mem_primary_data, primary_write_data_bus, second_write_data_bus;
  logic [15:0]       second_read_data_bus, primary_read_data_bus;
  logic [31:0]       mem_coeff_data, mem_code_data, coeff_read_data_bus, program_read_data_bus;
  logic [3:0]        rv;
  logic [3:0][31:0]  rd_d;
  int                mismatches = 0, checked = 0;
  always #50 sys_clk = ~sys_clk;
  cbs_bus_set u_dut (.*);
  cbs_mem_model u_mem (.sys_clk(sys_clk), .reset(reset), .slow(slow), .ret_v(rv), .ret_d(rd_d),
    .req_v({program_read_address_valid, coeff_read_address_valid, second_read_address_valid,
            primary_read_address_valid}),
    .req_a({program_read_address_bus, 1'b0, coeff_read_address_bus, 1'b0, second_read_address_bus,
            1'b0, primary_read_address_bus}));
  assign {mem_code_valid, mem_coeff_valid, mem_second_valid, mem_primary_valid} = rv;
  assign mem_code_data = rd_d[3];
  assign mem_coeff_data = rd_d[2];
  assign mem_second_data = rd_d[1][15:0];
  assign mem_primary_data = rd_d[0][15:0];
  function automatic logic [31:0] mdat(input logic [23:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction : mdat
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic results();
    if (mismatches == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  task automatic rd(input logic [2:0] k, input logic [1:0] d, input logic [22:0] ca);
    logic [22:0] sa, pa;
    logic qc, qs, qp, off;
    logic [2:0] rt;
    int n;
    sa = ca + 23'h000011;
    pa = ca + 23'h000022;
    qc = k == CBS_RD_COEFF || k == CBS_RD_QUAD;
    qs = k == CBS_RD_DUAL || k == CBS_RD_QUAD;
    qp = qs || k == CBS_RD_SINGLE;
    off = qc && ca >= INT_WORDS_DEF;
    rt = (d == 2'h3) ? 3'h0 : 3'h1 << d;
    @(posedge sys_clk);
    au_rd_kind <= k;
    au_rd_dest <= d;
    au_coeff_addr <= ca;
    au_second_addr <= sa;
    au_primary_addr <= pa;
    @(posedge sys_clk);
    au_rd_kind <= CBS_RD_IDLE;
    #1;
    chk("coeff_addr_valid", qc && !off, coeff_read_address_valid);
    chk("second_addr_valid", qs && !off, second_read_address_valid);
    chk("primary_addr_valid", qp && !off, primary_read_address_valid);
    chk("bus_error", off, bus_error);
    if (off)
      return;
    if (qp)
      chk("primary_addr", pa, primary_read_address_bus);
    if (qc)
      chk("coeff_addr", ca, coeff_read_address_bus);
    n = 0;
    while (!(cu_coeff_valid | pf_primary_valid | au_primary_valid | cu_primary_valid) && n < 10) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("coeff_valid", qc, cu_coeff_valid);
    chk("primary_route", qp ? rt : 3'h0, {cu_primary_valid, au_primary_valid, pf_primary_valid});
    chk("second_route", qs ? rt : 3'h0, {cu_second_valid, au_second_valid, pf_second_valid});
    if (qc)
      chk("coeff_data", mdat({1'b0, ca}), coeff_read_data_bus);
    if (qs)
      chk("second_data", 16'(mdat({1'b0, sa})), second_read_data_bus);
    if (qp)
      chk("primary_data", 16'(mdat({1'b0, pa})), primary_read_data_bus);
  endtask : rd
  task automatic wr(input logic [1:0] k, input logic [1:0] s);
    logic [1:0] u;
    u = (s > 2'h1) ? 2'h2 : s;
    @(posedge sys_clk);
    au_wr_kind <= k;
    au_wr_src <= s;
    au_wr_primary_addr <= 23'h000400 + 23'(s);
    au_wr_second_addr <= 23'h7ffff0 - 23'(s);
    @(posedge sys_clk);
    au_wr_kind <= CBS_WR_IDLE;
    #1;
    chk("wr_primary_valid", 1'b1, primary_write_valid);
    chk("wr_second_valid", k == CBS_WR_DUAL, second_write_valid);
    chk("wr_primary_addr", 23'h000400 + 23'(s), primary_write_address_bus);
    chk("wr_primary_data", 16'h1111 + 16'h2222 * u, primary_write_data_bus);
    if (k == CBS_WR_DUAL)
      chk("wr_second_data", 16'h2222 + 16'h2222 * u, second_write_data_bus);
  endtask : wr
  task automatic fetch(input logic [23:0] a);
    int n;
    @(posedge sys_clk);
    pf_fetch_req <= 1'b1;
    pf_fetch_addr <= a;
    @(posedge sys_clk);
    pf_fetch_req <= 1'b0;
    #1;
    chk("fetch_valid", 1'b1, program_read_address_valid);
    chk("fetch_addr", {a[23:2], 2'b00}, program_read_address_bus);
    n = 0;
    while (!decode_code_valid && n < 10) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("code_valid", 1'b1, decode_code_valid);
    chk("code_data", mdat({a[23:2], 2'b00}), program_read_data_bus);
  endtask : fetch
  initial begin
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    for (int m = 0; m < 2; m++) begin
      slow <= m[0];
      for (int k = 1; k <= 4; k++)
        rd(3'(k), 2'(k % 3), INT_WORDS_DEF - 23'(k + 4 * m));
      fetch(m[0] ? 24'h123457 : 24'hfffffe);
    end
    rd(CBS_RD_SINGLE, 2'h3, 23'h000123);
    rd(3'h5, 2'h0, 23'h000040);
    rd(CBS_RD_QUAD, 2'h2, INT_WORDS_DEF);
    rd(CBS_RD_COEFF, 2'h1, 23'h7fffff);
    for (int s = 0; s < 4; s++) begin
      wr(CBS_WR_SINGLE, 2'(s));
      wr(CBS_WR_DUAL, 2'(s));
    end
    results();
  end
  // whole run needs about 115 cycles; some 26 times that means a hang
  initial begin
    #(3000 * 100);
    mismatches++;
    results();
  end
endmodule : cbs_bus_set_tb
bind cbs_bus_set cbs_bus_set_assertions #(.INT_WORDS(INT_WORDS)) u_chk (.*);
